/* File: rtl/tmr_pkg.sv */
// Constants shared by the eight-bit timer and its phase generator.
package tmr_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [6:0] TMR_ADDR_INTCTL = 7'h0B;
  localparam logic [6:0] TMR_ADDR_COUNT = 7'h15;
  localparam logic [6:0] TMR_ADDR_OPTION = 7'h16;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int TMR_INTCTL_IRQ_EN_BIT = 5;
  localparam int TMR_INTCTL_FLAG_BIT = 2;
  localparam int TMR_OPT_SRC_BIT = 5;
  localparam int TMR_OPT_BYPASS_BIT = 3;
  localparam int TMR_OPT_SEL_LSB = 0;
  localparam int TMR_OPT_SEL_W = 3;
  localparam logic [7:0] TMR_OPT_MASK = 8'h2F;
  localparam logic [7:0] TMR_INTCTL_RST = 8'h00;
  localparam logic [7:0] TMR_COUNT_RST = 8'h00;
  localparam logic [7:0] TMR_OPT_RST = 8'h00;
  localparam logic [7:0] TMR_COUNT_MAX = 8'hFF;

  // ****************************************
  // Instruction cycle phases
  // ****************************************
  localparam int TMR_PHASES = 4;
  typedef enum logic [3:0] {
    TMR_PH_ONE = 4'h1,
    TMR_PH_TWO = 4'h2,
    TMR_PH_THREE = 4'h4,
    TMR_PH_FOUR = 4'h8
  } tmr_phase_t;

endpackage : tmr_pkg

/* File: rtl/tmr_phase_sync.sv */
// Instruction phase sequencer and two-flop synchroniser for the count pin.
`timescale 1ns/1ps
module tmr_phase_sync
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // External pin and results
  input wire logic pin_in,
  output logic pin_sync_out,
  output logic phase_two_out,
  output logic phase_four_out
);

  tmr_phase_t phase_q;
  tmr_phase_t phase_d;
  logic meta_q;
  logic sync_q;

  // Four phases make one instruction cycle.
  always_comb begin
    case (phase_q)
      TMR_PH_ONE: phase_d = TMR_PH_TWO;
      TMR_PH_TWO: phase_d = TMR_PH_THREE;
      TMR_PH_THREE: phase_d = TMR_PH_FOUR;
      TMR_PH_FOUR: phase_d = TMR_PH_ONE;
      default: phase_d = TMR_PH_ONE;
    endcase
  end

  // Phase register advances only while the clock enable is high.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_q <= TMR_PH_ONE;
    end else if (ce_in) begin
      phase_q <= phase_d;
    end
  end

  // The first stage feeds only the second, so metastability never reaches logic.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else if (ce_in) begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  // Outputs.
  assign pin_sync_out = sync_q;
  assign phase_two_out = (phase_q == TMR_PH_TWO);
  assign phase_four_out = (phase_q == TMR_PH_FOUR);

endmodule : tmr_phase_sync

/* File: rtl/tmr_timer8.sv */
// Eight-bit timer/counter with prescaler, overflow flag and sleep freeze.
// Functional notes
// [RULE1] The prescaler sits in the count path only while the bypass bit is clear.
// [RULE2] With the bypass bit set the count steps once per input event.
// [RULE3] Eight prescale ratios from 1:2 to 1:256 are chosen by a 3-bit select field.
// [RULE4] Select value n divides by two to the power n+1.
// [RULE5] The prescaler count is never visible to or writable by software.
// [RULE6] Any write to the count register also clears the prescaler.
// [RULE7] This prescaler serves the timer alone; the watchdog keeps its own.
// [RULE8] The interrupt condition rises when the count wraps from FFh to 00h.
// [RULE9] Every wrap sets the overflow flag whatever the interrupt enable says.
// [RULE10] Hardware never clears the overflow flag; software clears it by a write.
// [RULE11] An overflow reaches the interrupt request only when its enable bit is set.
// [RULE12] In counter mode the external count edge is synchronised to the instruction clock.
// [RULE13] Synchronisation samples the prescaler output on phase two and phase four.
// [RULE14] During sleep the timer stops and the count register holds its value.
// [RULE15] A timer overflow is never a wake-up source from sleep.
// [RULE16] In timer mode the prescaler, or the count when bypassed, steps once per instruction cycle.
`timescale 1ns/1ps
module tmr_timer8
  import tmr_pkg::*;
#(
  parameter int PRE_W = 8
) (
  // Clock, reset and enables
  input wire logic REF_CLK_IN,
  input wire logic NRST_IN,
  input wire logic CE_IN,
  input wire logic SLEEP_IN,
  // Core register port
  input wire logic [6:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WE_IN,
  input wire logic REG_RE_IN,
  output logic [7:0] REG_RDATA_OUT,
  // Pin and interrupt
  input wire logic EXT_COUNT_IN,
  output logic IRQ_OUT
);

  // ****************************************
  // Reset release and phases
  // ****************************************
  logic rst_meta_q;
  logic rst_n_q;
  logic pin_sync;
  logic phase_two;
  logic phase_four;

  // Reset asserts at once and releases through two flops.
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  tmr_phase_sync u_phase (
    .clk_in(REF_CLK_IN),
    .rst_n_in(rst_n_q),
    .ce_in(CE_IN),
    .pin_in(EXT_COUNT_IN),
    .pin_sync_out(pin_sync),
    .phase_two_out(phase_two),
    .phase_four_out(phase_four)
  );

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] intctl_q;
  logic [7:0] option_q;
  logic [7:0] count_q;
  logic [PRE_W-1:0] pre_q;
  logic pin_prev_q;
  logic samp_q;
  logic pre_out_prev_q;
  logic wr_intctl;
  logic wr_count;
  logic wr_option;
  logic run;
  logic src_ext;
  logic bypass;
  logic [TMR_OPT_SEL_W-1:0] sel;
  logic event_in;
  logic pre_out;
  logic samp_d;
  logic inc;
  logic wrap;

  assign wr_intctl = REG_WE_IN && (REG_ADDR_IN == TMR_ADDR_INTCTL);
  assign wr_count = REG_WE_IN && (REG_ADDR_IN == TMR_ADDR_COUNT);
  assign wr_option = REG_WE_IN && (REG_ADDR_IN == TMR_ADDR_OPTION);
  assign run = CE_IN && !SLEEP_IN; // [RULE14]
  assign src_ext = option_q[TMR_OPT_SRC_BIT];
  assign bypass = option_q[TMR_OPT_BYPASS_BIT];
  assign sel = option_q[TMR_OPT_SEL_LSB +: TMR_OPT_SEL_W];

  // An input event is one instruction cycle in timer mode or a synchronised rising pin edge otherwise.
  assign event_in = src_ext ? (pin_sync && !pin_prev_q) : phase_four; // [RULE12] [RULE16]

  // Prescaler bit n toggles every 2^n events, so its rising edge divides by 2^(n+1).
  assign pre_out = pre_q[sel]; // [RULE3] [RULE4]

  // Counter mode samples its source only on phase two and phase four.
  assign samp_d = (phase_two || phase_four) ? (bypass ? pin_sync : pre_out) : samp_q; // [RULE13]

  // Pick the increment: bypass in timer mode steps straight on the cycle.
  always_comb begin
    if (src_ext) begin
      inc = samp_d && !samp_q && (phase_two || phase_four); // [RULE12] [RULE13]
    end else if (bypass) begin
      inc = event_in; // [RULE2] [RULE16]
    end else begin
      inc = pre_out && !pre_out_prev_q; // [RULE1]
    end
  end

  assign wrap = run && inc && !wr_count && (count_q == TMR_COUNT_MAX); // [RULE8]

  // Prescaler is private to the timer and cleared by any count write.
  always_ff @(posedge REF_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pre_q <= '0;
    end else if (CE_IN) begin
      if (wr_count) begin
        pre_q <= '0; // [RULE6] [RULE7]
      end else if (run && !bypass && event_in) begin
        pre_q <= pre_q + 1'b1; // [RULE1] [RULE16]
      end
    end
  end

  // Edge trackers, held during sleep, so an edge that arises in sleep still appears on wake.
  always_ff @(posedge REF_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_prev_q <= 1'b0;
      samp_q <= 1'b0;
      pre_out_prev_q <= 1'b0;
    end else if (run) begin
      pin_prev_q <= pin_sync;
      samp_q <= samp_d;
      pre_out_prev_q <= wr_count ? 1'b0 : pre_out;
    end
  end

  // Count register: a software write wins over a same-cycle increment.
  always_ff @(posedge REF_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      count_q <= TMR_COUNT_RST;
    end else if (CE_IN) begin
      if (wr_count) begin
        count_q <= REG_WDATA_IN;
      end else if (run && inc) begin
        count_q <= count_q + 8'h01; // [RULE14]
      end
    end
  end

  // Option register steering source, bypass and ratio.
  always_ff @(posedge REF_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      option_q <= TMR_OPT_RST;
    end else if (CE_IN && wr_option) begin
      option_q <= REG_WDATA_IN & TMR_OPT_MASK;
    end
  end

  // Interrupt control: the flag is set by hardware and only a write clears it; set beats clear.
  always_ff @(posedge REF_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      intctl_q <= TMR_INTCTL_RST;
    end else if (CE_IN) begin
      if (wr_intctl) begin
        intctl_q <= REG_WDATA_IN; // [RULE10]
      end
      if (wrap) begin
        intctl_q[TMR_INTCTL_FLAG_BIT] <= 1'b1; // [RULE9]
      end
    end
  end

  // Read data is registered; the prescaler has no address at all.
  always_ff @(posedge REF_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      REG_RDATA_OUT <= 8'h00;
    end else if (CE_IN && REG_RE_IN) begin
      case (REG_ADDR_IN)
        TMR_ADDR_INTCTL: REG_RDATA_OUT <= intctl_q;
        TMR_ADDR_COUNT: REG_RDATA_OUT <= count_q;
        TMR_ADDR_OPTION: REG_RDATA_OUT <= option_q; // [RULE5]
        default: REG_RDATA_OUT <= 8'h00;
      endcase
    end
  end

  // The request is a plain level with no wake path; sleep freezes the count, so no overflow can occur.
  assign IRQ_OUT = intctl_q[TMR_INTCTL_FLAG_BIT] && intctl_q[TMR_INTCTL_IRQ_EN_BIT]; // [RULE11] [RULE15]

  // ****************************************
  // Assertions
  // ****************************************
  a_wrap_sets_flag: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n_q) // [RULE9]
    wrap |=> intctl_q[TMR_INTCTL_FLAG_BIT]) else $error("overflow flag not set after wrap");
  a_flag_no_hw_clear: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n_q) // [RULE10]
    $fell(intctl_q[TMR_INTCTL_FLAG_BIT]) |-> $past(wr_intctl)) else $error("flag cleared without write");
  a_irq_gated_enable: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n_q) // [RULE11]
    $rose(IRQ_OUT) |-> $past(CE_IN && (wrap || wr_intctl)) && intctl_q[TMR_INTCTL_IRQ_EN_BIT])
    else $error("irq rose without an overflow or register write, or without enable");
  a_wrap_to_zero: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n_q) // [RULE8]
    wrap |=> count_q == 8'h00) else $error("count did not wrap to zero");
  a_sleep_holds_count: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n_q) // [RULE14]
    SLEEP_IN && !wr_count |=> $stable(count_q)) else $error("count moved during sleep");
  a_write_clears_pre: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n_q) // [RULE6]
    CE_IN && wr_count |=> pre_q == '0) else $error("prescaler not cleared by count write");
  a_bypass_pre_idle: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n_q) // [RULE1]
    bypass && !wr_count && CE_IN |=> $stable(pre_q)) else $error("prescaler moved while bypassed");
  a_timer_bypass_rate: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n_q) // [RULE16]
    run && !src_ext && bypass && phase_four && !wr_count && !wr_option |=> count_q == $past(count_q) + 8'h01)
    else $error("bypassed timer missed an instruction cycle");
  a_ext_on_phases: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n_q) // [RULE13]
    run && src_ext && !wr_count && !(phase_two || phase_four) |=> $stable(count_q))
    else $error("counter step off phase two or four");

endmodule : tmr_timer8

/* File: verif/tmr_timer8_test.sv */
// Self-checking testbench for the eight-bit timer.
`timescale 1ns/1ps
module tmr_timer8_test;
  import tmr_pkg::*;
  // ****************************************
  // Stimulus signals and score
  // ****************************************
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic slp = 1'b1;
  logic [6:0] addr = 7'h00;
  logic [7:0] wdat = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  logic pin = 1'b0;
  logic [7:0] rdat;
  logic irq;
  int n_fail = 0;
  int checks_done = 0;

  tmr_timer8 #(.PRE_W(8)) i_dut (
    .REF_CLK_IN(clk), .NRST_IN(nrst), .CE_IN(ce), .SLEEP_IN(slp),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdat), .REG_WE_IN(we), .REG_RE_IN(re),
    .REG_RDATA_OUT(rdat), .EXT_COUNT_IN(pin), .IRQ_OUT(irq)
  );

  // Free-running 200 MHz clock.
  initial begin
    forever #2.5 clk = ~clk;
  end

  // Accepts either lo or hi, since phase alignment may shift a step by one.
  task automatic chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    checks_done++;
    if (!(got === lo || got === hi)) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h..%h", $time, got, lo, hi);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // One-cycle write strobe, changed on the falling edge.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdat = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask : wr

  // Read data is sampled one and a half cycles after the read edge.
  task automatic rd(input logic [6:0] a);
    @(negedge clk);
    addr = a;
    re = 1'b1;
    @(negedge clk);
    re = 1'b0;
    @(negedge clk);
  endtask : rd

  task automatic pulses(input int n);
    repeat (n) begin
      pin = 1'b1;
      cyc(8);
      pin = 1'b0;
      cyc(8);
    end
  endtask : pulses

  task automatic t_reset;
    rd(TMR_ADDR_INTCTL); chk(rdat, 8'h00, 8'h00);
    rd(TMR_ADDR_COUNT); chk(rdat, 8'h00, 8'h00);
    rd(TMR_ADDR_OPTION); chk(rdat, 8'h00, 8'h00);
    rd(7'h20); chk(rdat, 8'h00, 8'h00);
    wr(TMR_ADDR_OPTION, 8'hFF);
    rd(TMR_ADDR_OPTION); chk(rdat, 8'h2F, 8'h2F);
    $display("test reset done");
  endtask : t_reset

  // Exactly three steps fit in a window of three full division periods; a doubled ratio gives fewer.
  task automatic t_ratio;
    logic [7:0] opt;
    int r;
    for (int n = 0; n < 9; n++) begin
      opt = (n == 8) ? 8'h08 : 8'(n);
      r = (n == 8) ? 1 : (2 << n);
      slp = 1'b0;
      wr(TMR_ADDR_OPTION, opt);
      wr(TMR_ADDR_COUNT, 8'h00);
      cyc(12 * r);
      slp = 1'b1;
      rd(TMR_ADDR_COUNT); chk(rdat, 8'h03, 8'h03);
    end
    $display("test ratio done");
  endtask : t_ratio

  task automatic t_wrap;
    slp = 1'b0;
    wr(TMR_ADDR_OPTION, 8'h07);
    wr(TMR_ADDR_COUNT, 8'hFF);
    slp = 1'b1;
    cyc(400);
    rd(TMR_ADDR_COUNT); chk(rdat, 8'hFF, 8'hFF);
    rd(TMR_ADDR_INTCTL); chk(rdat, 8'h00, 8'h00);
    slp = 1'b0;
    cyc(1040);
    slp = 1'b1;
    rd(TMR_ADDR_COUNT); chk(rdat, 8'h00, 8'h00);
    cyc(40);
    rd(TMR_ADDR_INTCTL); chk(rdat, 8'h04, 8'h04);
    chk({7'h00, irq}, 8'h00, 8'h00);
    wr(TMR_ADDR_INTCTL, 8'h24);
    chk({7'h00, irq}, 8'h01, 8'h01);
    wr(TMR_ADDR_INTCTL, 8'h20);
    rd(TMR_ADDR_INTCTL); chk(rdat, 8'h20, 8'h20);
    chk({7'h00, irq}, 8'h00, 8'h00);
    $display("test wrap done");
  endtask : t_wrap

  // At 1:256 the top prescaler bit first rises after 128 events; each window holds about 100.
  // Without the clear the two windows would add to 200 events and step the count once.
  task automatic t_clear;
    slp = 1'b0;
    wr(TMR_ADDR_COUNT, 8'h00);
    cyc(400);
    wr(TMR_ADDR_COUNT, 8'h00);
    cyc(400);
    slp = 1'b1;
    rd(TMR_ADDR_COUNT); chk(rdat, 8'h00, 8'h00);
    $display("test clear done");
  endtask : t_clear

  task automatic t_counter;
    slp = 1'b0;
    wr(TMR_ADDR_OPTION, 8'h28);
    wr(TMR_ADDR_COUNT, 8'h00);
    pulses(5);
    cyc(12);
    rd(TMR_ADDR_COUNT); chk(rdat, 8'h05, 8'h05);
    wr(TMR_ADDR_OPTION, 8'h20);
    wr(TMR_ADDR_COUNT, 8'h00);
    pulses(8);
    cyc(12);
    rd(TMR_ADDR_COUNT); chk(rdat, 8'h04, 8'h04);
    ce = 1'b0;
    wr(TMR_ADDR_COUNT, 8'h55);
    ce = 1'b1;
    rd(TMR_ADDR_COUNT); chk(rdat, 8'h04, 8'h04);
    $display("test counter done");
  endtask : t_counter

  task automatic wrap_up;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // Main sequence: three-cycle reset, then the scenarios.
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    cyc(3);
    t_reset();
    t_ratio();
    t_wrap();
    t_clear();
    t_counter();
    wrap_up();
  end

  // The run needs about 9000 cycles; a hang is cut off at 20000, well short of any runaway.
  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end
endmodule : tmr_timer8_test
